// >>> fps_sequencer.sv
// four-phase clock divider and two-stage fetch/execute sequencer
//
// Contract
// - The clock is divided by four into four ordered phases.
// - The fetch counter steps in phase one, the word lands in four.
// - The word is latched in phase one and runs in phases two to four.
// - Operand read is in phase two, destination write in phase four.
// - Fetch of the next word overlaps execution of the current one.
// - A taken branch drops the prefetched word, costing two cycles.
// - The fetch address counter is 13 bits wide.
// - Space is 512, 1K or 2K words and higher addresses wrap into it.
// - Execution starts at 0000h after reset; interrupts go to 0004h.
// - In resistor-capacitor mode the cycle output runs at clock/4.
// - Holding master clear low keeps the sequencer in reset.
// - A whole 14-bit word is read over a 14-bit bus in one cycle.
//
// timing summary: one core clock per phase, four per instruction cycle;
// address goes out at the edge closing phase one;
// word taken at the edge closing phase four, straight into the latch;
// so it executes next cycle while the following word is fetched;
// branch or interrupt sampled at that same edge;
// the word fetched alongside a redirect becomes a blank slot,
// which is why a redirect costs two cycles
//
// limitations: no stall input, memory must answer within three clocks;
// mode input is a same-clock configuration level, not synchronised
`include "fps_defines.svh"
module fps_sequencer
    import fps_pkg::*;
#(
    parameter fps_size_t MEM_SIZE = FPS_SIZE_2K
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // pins
    input wire logic master_clear_n_i,
    input wire logic resistor_capacitor_osc_mode_i,
    output logic cycle_rate_output_o,
    // program memory
    output logic [`FPS_PC_W-1:0] prog_addr_o,
    input wire logic [`FPS_INSN_W-1:0] prog_data_i,
    // control from the execution unit
    input wire logic branch_i,
    input wire logic [`FPS_PC_W-1:0] branch_target_i,
    input wire logic irq_take_i,
    // toward the execution datapath
    output fps_phases_t phases_o,
    output fps_slots_t slots_o,
    output logic [`FPS_INSN_W-1:0] instruction_latch_o,
    output logic [`FPS_PC_W-1:0] fetch_address_counter_o
);
    fps_phase_t phase;
    fps_phase_t next_phase;
    // pin synchroniser and combined reset
    logic clear_meta;
    logic clear_sync;
    logic rst;
    // pipeline state
    logic fetch_ok;
    logic exec_ok;
    logic next_exec_ok;
    logic redirect;
    logic [`FPS_PC_W-1:0] redirect_addr;
    logic [`FPS_PC_W-1:0] fetch_cnt;

    // wrap an address into the implemented space;
    // masking is cheap, upper counter bits never reach memory
    function automatic logic [`FPS_PC_W-1:0] wrap_addr(
        input logic [`FPS_PC_W-1:0] a
    );
        logic [`FPS_PC_W-1:0] m;
        m = `FPS_MASK_2K;
        unique case (MEM_SIZE)
            FPS_SIZE_512: m = `FPS_MASK_512;
            FPS_SIZE_1K: m = `FPS_MASK_1K;
            FPS_SIZE_2K: m = `FPS_MASK_2K;
            default: m = `FPS_MASK_2K;
        endcase
        return a & m;
    endfunction

    // master clear pin synchroniser, two flops before use;
    // no reset here so the pin alone can pull the block down
    always_ff @(posedge core_clk_i) begin
        clear_meta <= master_clear_n_i;
        clear_sync <= clear_meta;
    end

    // master clear reset
    // pin acts two edges late; hold it low three edges at least
    assign rst = sys_rst_i | ~clear_sync;

    always_comb begin
        unique case (phase)
            FPS_PH1: next_phase = FPS_PH2;
            FPS_PH2: next_phase = FPS_PH3;
            FPS_PH3: next_phase = FPS_PH4;
            FPS_PH4: next_phase = FPS_PH1;
            default: next_phase = FPS_PH1;
        endcase
    end

    // phase register; reset parks it in phase four so the
    // first edge out of reset enters phase one
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            phase <= FPS_PH4;
        end else begin
            phase <= next_phase;
        end
    end

    // redirect sampled at end of the execution cycle; interrupt wins;
    // a flushed slot runs nothing, so requests there drop silently
    always_comb begin
        redirect = 1'b0;
        redirect_addr = branch_target_i;
        if (phase == FPS_PH4 && exec_ok) begin
            if (irq_take_i) begin
                redirect = 1'b1;
                redirect_addr = `FPS_IRQ_VECTOR;
            end else if (branch_i) begin
                redirect = 1'b1;
                redirect_addr = branch_target_i;
            end
        end
    end

    // counter steps in phase one, wraps
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            fetch_cnt <= `FPS_RESET_VECTOR;
            prog_addr_o <= `FPS_RESET_VECTOR;
        end else if (redirect) begin
            // new address is fetched next cycle, then counter steps past it
            fetch_cnt <= wrap_addr(redirect_addr);
        end else if (phase == FPS_PH1) begin
            // address then holds for four clocks; the word is taken after three, the memory's budget
            prog_addr_o <= fetch_cnt;
            fetch_cnt <= wrap_addr(fetch_cnt + 13'h0001);
        end
    end

    // a fetch is real once its address went out after reset;
    // the edge straight out of reset is a phase four with nothing fetched
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            fetch_ok <= 1'b0;
        end else if (phase == FPS_PH1) begin
            fetch_ok <= 1'b1;
        end
    end

    // blank slot on redirect or before first fetch
    always_comb begin
        next_exec_ok = exec_ok;
        if (phase == FPS_PH4) begin
            next_exec_ok = fetch_ok & ~redirect;
        end
    end

    // whole word into the latch
    // at the edge closing phase four, which opens phase one;
    // one register, not two, keeps the pipeline at two stages
    // latch overlaps next fetch
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            instruction_latch_o <= `FPS_NOP_WORD;
            exec_ok <= 1'b0;
        end else begin
            if (phase == FPS_PH4) begin
                instruction_latch_o <= next_exec_ok ? prog_data_i
                    : `FPS_NOP_WORD;
            end
            exec_ok <= next_exec_ok;
        end
    end

    // registered phase and slot strobes, aligned with phase;
    // built from next values so every output leaves a flop
    // yet lines up with the internal phase register
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            phases_o <= '0;
            slots_o <= '0;
            fetch_address_counter_o <= `FPS_RESET_VECTOR;
        end else begin
            phases_o.phase_one <= (next_phase == FPS_PH1);
            phases_o.phase_two <= (next_phase == FPS_PH2);
            phases_o.phase_three <= (next_phase == FPS_PH3);
            phases_o.phase_four <= (next_phase == FPS_PH4);
            // insn latch strobe in phase one
            slots_o.insn_load <= (next_phase == FPS_PH1);
            // read in phase two, write in phase four
            slots_o.operand_read <= (next_phase == FPS_PH2) & next_exec_ok;
            slots_o.dest_write <= (next_phase == FPS_PH4) & next_exec_ok;
            slots_o.exec_valid <= next_exec_ok;
            fetch_address_counter_o <= fetch_cnt;
        end
    end

    // cycle rate output, high in phases three and four
    // taken from the divider, not the raw clock, so it keeps step
    // with the strobes; held low outside that oscillator mode
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            cycle_rate_output_o <= 1'b0;
        end else begin
            cycle_rate_output_o <= resistor_capacitor_osc_mode_i &
                (next_phase == FPS_PH3 || next_phase == FPS_PH4);
        end
    end
endmodule // fps_sequencer

// >>> fps_defines.svh
// timing counts, vectors and sizes for the fetch pipeline sequencer
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH
`define FPS_PC_W 13
`define FPS_INSN_W 14
`define FPS_RESET_VECTOR 13'h0000
`define FPS_IRQ_VECTOR 13'h0004
`define FPS_MASK_512 13'h01FF
`define FPS_MASK_1K 13'h03FF
`define FPS_MASK_2K 13'h07FF
`define FPS_NOP_WORD 14'h0000
`define FPS_PHASES 4
`endif

// >>> fps_pkg.sv
// types shared by the fetch pipeline sequencer
package fps_pkg;
    // one-hot phase within an instruction cycle
    typedef enum logic [3:0] {
        FPS_PH1 = 4'h1,
        FPS_PH2 = 4'h2,
        FPS_PH3 = 4'h4,
        FPS_PH4 = 4'h8
    } fps_phase_t;
    // program memory variant size
    typedef enum logic [1:0] {
        FPS_SIZE_512 = 2'h0,
        FPS_SIZE_1K = 2'h1,
        FPS_SIZE_2K = 2'h2
    } fps_size_t;
    // strobes toward the execution datapath
    typedef struct packed {
        logic phase_one;
        logic phase_two;
        logic phase_three;
        logic phase_four;
    } fps_phases_t;
    typedef struct packed {
        logic insn_load;
        logic operand_read;
        logic dest_write;
        logic exec_valid;
    } fps_slots_t;
endpackage

// >>> fps_prog_mem.sv
// program memory model with a settable read delay
module fps_prog_mem #(parameter int LAT = 1) (
    // fetch side
    input wire logic clk_i,
    input wire logic [12:0] addr_i,
    output logic [13:0] data_o
);
    logic [12:0] held = 13'h0000;
    int age = 0;
    // a moving address shows the old word for one clock, then the inverse word until LAT clocks pass
    always @(posedge clk_i) begin
        age <= addr_i == held ? age + 1 : 0;
        held <= addr_i;
    end
    assign data_o = age >= LAT ? {1'b1, held} : ~{1'b1, held};
endmodule // fps_prog_mem

// >>> fps_sequencer_monitor.sv
// port assertions for the fetch pipeline sequencer
`include "fps_defines.svh"
module fps_sequencer_monitor import fps_pkg::*;
#(parameter fps_size_t MEM_SIZE = FPS_SIZE_2K) (
    // watched ports
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic master_clear_n_i,
    input wire logic [`FPS_PC_W-1:0] prog_addr_o,
    input wire logic [`FPS_INSN_W-1:0] instruction_latch_o,
    input wire logic branch_i,
    input wire logic [`FPS_PC_W-1:0] branch_target_i,
    input wire logic irq_take_i,
    input wire fps_phases_t phases_o,
    input wire fps_slots_t slots_o
);
    localparam logic [12:0] M = MEM_SIZE == FPS_SIZE_512 ? `FPS_MASK_512 :
        MEM_SIZE == FPS_SIZE_1K ? `FPS_MASK_1K : `FPS_MASK_2K;
    // redirect only counts in an executing phase four
    wire logic jmp = phases_o.phase_four && slots_o.exec_valid &&
        (branch_i || irq_take_i);
    default clocking @(posedge core_clk_i); endclocking
    // pin clear acts late through its synchroniser
    default disable iff (sys_rst_i || !master_clear_n_i);
    property p_ring; phases_o.phase_one |=> phases_o.phase_two ##1
        phases_o.phase_three ##1 phases_o.phase_four ##1 phases_o.phase_one;
    endproperty
    a_ring: assert property (p_ring) else $error("phase order");
    property p_step; logic [12:0] a;
        (phases_o.phase_four && !jmp, a = prog_addr_o) |->
        ##2 prog_addr_o == ((a + 13'h1) & M);
    endproperty
    a_step: assert property (p_step) else $error("fetch step");
    property p_jump; logic [12:0] a;
        (jmp && !irq_take_i, a = branch_target_i) |-> ##2 prog_addr_o == (a & M);
    endproperty
    a_jump: assert property (p_jump) else $error("branch");
    property p_irq; jmp && irq_take_i |-> ##2 prog_addr_o == `FPS_IRQ_VECTOR;
    endproperty
    a_irq: assert property (p_irq) else $error("vector");
    property p_flush; jmp |=> !slots_o.exec_valid [*4]; endproperty
    a_flush: assert property (p_flush) else $error("flush");
    property p_load; !slots_o.insn_load |-> $stable(instruction_latch_o);
    endproperty
    a_load: assert property (p_load) else $error("load slot");
    property p_rd; slots_o.operand_read ==
        (phases_o.phase_two && slots_o.exec_valid); endproperty
    a_rd: assert property (p_rd) else $error("read slot");
    property p_wr; slots_o.dest_write ==
        (phases_o.phase_four && slots_o.exec_valid); endproperty
    a_wr: assert property (p_wr) else $error("write slot");
    c_jump: cover property (jmp && !irq_take_i);
    c_irq: cover property (jmp && irq_take_i);
    c_wrap: cover property (prog_addr_o == M);
endmodule // fps_sequencer_monitor
bind fps_sequencer fps_sequencer_monitor #(.MEM_SIZE(MEM_SIZE))
    fps_sequencer_monitor_inst (.core_clk_i, .sys_rst_i, .master_clear_n_i,
    .prog_addr_o, .instruction_latch_o, .branch_i, .branch_target_i,
    .irq_take_i, .phases_o,
    .slots_o);

// >>> fps_sequencer_test.sv
// self-checking bench for the fetch pipeline sequencer
`include "fps_defines.svh"
module fps_sequencer_test import fps_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 0, sys_rst_i = 1, clear_n = 1, osc_mode = 0;
    logic br = 0, irq = 0;
    logic cro;
    logic [12:0] tgt = 13'h0000, addr, fac;
    logic [13:0] data, latch;
    fps_phases_t ph;
    fps_slots_t sl;
    int n_mismatch = 0, check_count = 0;
    fps_sequencer #(.MEM_SIZE(FPS_SIZE_512)) fps_sequencer_inst (
        .core_clk_i, .sys_rst_i, .master_clear_n_i(clear_n),
        .resistor_capacitor_osc_mode_i(osc_mode), .cycle_rate_output_o(cro),
        .prog_addr_o(addr), .prog_data_i(data), .branch_i(br),
        .branch_target_i(tgt), .irq_take_i(irq), .phases_o(ph),
        .slots_o(sl), .instruction_latch_o(latch),
        .fetch_address_counter_o(fac));
    fps_prog_mem fps_prog_mem_inst (.clk_i(core_clk_i), .addr_i(addr),
        .data_o(data));
    // free-running clock
    initial forever #50 core_clk_i = ~core_clk_i;
    task automatic tick(int n);
        repeat (n) @(posedge core_clk_i);
        #10;
    endtask
    task automatic check(logic [13:0] seen, logic [13:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // bounded wait for an executing phase four
    task automatic to_p4();
        int n;
        for (n = 0; n < 16 && (ph.phase_four & sl.exec_valid) !== 1'b1; n++)
            tick(1);
        if (n == 16) begin
            n_mismatch++;
            wrap_up();
        end
    endtask
    task automatic t_start();
        check(addr, `FPS_RESET_VECTOR);
        to_p4();
        check(latch, 14'h2000);
        check(addr, 13'h0001);
        check(fac, 13'h0002);
        tick(4);
        check(latch, 14'h2001);
    endtask
    // redirect; the request held over the flushed slot must be ignored
    task automatic t_jump(logic b, i, logic [12:0] t, e);
        to_p4();
        {br, irq, tgt} = {b, i, t};
        tick(1);
        check(latch, `FPS_NOP_WORD);
        tick(1);
        check(addr, e);
        tick(3);
        {br, irq} = 2'h0;
        check(latch, {1'b1, e});
        tick(1);
        check(addr, (e + 13'h1) & 13'h01FF);
    endtask
    task automatic t_rc();
        int k;
        osc_mode = 1;
        tick(1);
        to_p4();
        for (k = 0; k < 4; k++) begin
            check(cro, 14'(4'b1001 >> k & 1));
            tick(1);
        end
        osc_mode = 0;
    endtask
    task automatic t_master_clear_n();
        clear_n = 0;
        tick(4);
        check(ph, 4'h0);
        clear_n = 1;
        to_p4();
        check(latch, 14'h2000);
    endtask
    initial begin
        tick(4);
        sys_rst_i = 0;
        t_start();
        t_jump(1, 0, 13'h1FFE, 13'h01FE);
        t_jump(1, 1, 13'h0100, `FPS_IRQ_VECTOR);
        t_rc();
        t_master_clear_n();
        wrap_up();
    end
endmodule // fps_sequencer_test
